// >>> design/parallel_config_port_defines.vh
// Constants for the parallel configuration port: offsets, fields, codes and timing.
`ifndef PARALLEL_CONFIG_PORT_DEFINES_VH
`define PARALLEL_CONFIG_PORT_DEFINES_VH

`define CLK_FREQ_MHZ        32'd25
`define CLEAR_TIME_NS       32'd1000
`define CLEAR_CYCLES        ((`CLEAR_TIME_NS * `CLK_FREQ_MHZ + 32'd999) / 32'd1000)

`define OFFS_CONTROL        4'h0
`define OFFS_STATUS         4'h4

`define CTRL_TOTEM_BIT      0
`define CTRL_PERSIST_BIT    1
`define CTRL_THROTTLE_BIT   2
`define CTRL_LEN_LSB        8
`define CTRL_LEN_MSB        15
`define CTRL_RESET          16'h0100

`define STAT_STATE_LSB      0
`define STAT_MODE_LSB       2
`define STAT_FINISH_BIT     5
`define STAT_BUSY_BIT       6
`define STAT_RDBK_BIT       7
`define STAT_COUNT_LSB      8

`define MODE_MASTER_SERIAL  3'h0
`define MODE_MASTER_PAR     3'h3
`define MODE_BOUNDARY_SCAN  3'h5
`define MODE_SLAVE_PAR      3'h6
`define MODE_SLAVE_SERIAL   3'h7

`define RESP_OKAY           2'h0
`define RESP_DECERR         2'h3

`endif

// >>> design/parallel_config_port.v
// Configuration-side logic with a byte-wide parallel load and readback port.
// Function
// - config clock: slave input, master output
// - program input resets config logic asynchronously
// - finish output rises when configuration completes
// - drive style selects totem-pole or open-drain finish
// - held-low open-drain finish delays user mode
// - mode pins latched on init rising edge
// - pullup_disable low enables pull-ups during configuration
// - eight-bit bus, bytes on config clock rise
// - lines zero to three carry high nibble
// - bus input when loading, output on readback
// - byte written when select and read_write low
// - readback: select low, read_write high drives byte
// - select high ignores all port inputs
// - readback only with pin retention enabled
// - retention keeps port pins after user mode
// - flow control low: next byte accepted
// - flow control high: byte ignored, re-presented
// - flow control released while select high
// - boundary-scan mode frees all dual pins
// - dual pins become user pins after configuration
// - without retention, config pins become user pins
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "parallel_config_port_defines.vh"

module parallel_config_port #(
	parameter ADDR_W      = 4,
	parameter DEPTH_W     = 4,
	parameter CLOCK_DIV   = 4
) (
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire              s_axi_awvalid,
	output reg               s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output reg               s_axi_wready,
	output reg  [1:0]        s_axi_bresp,
	output reg               s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire              s_axi_arvalid,
	output reg               s_axi_arready,
	output reg  [31:0]       s_axi_rdata,
	output reg  [1:0]        s_axi_rresp,
	output reg               s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              program_reset_n,
	input  wire              config_clock_in,
	output reg               config_clock_out,
	output reg               config_clock_oe,
	input  wire [2:0]        mode_select_pins,
	input  wire              pullup_disable,
	output reg               pullup_enable,
	input  wire              select_n,
	input  wire              read_write_n,
	input  wire [7:0]        config_byte_bus_in,
	output reg  [7:0]        config_byte_bus_out,
	output reg               config_byte_bus_oe,
	output reg               busy_out,
	output reg               busy_oe,
	input  wire              finish_in,
	output reg               finish_out,
	output reg               finish_oe,
	input  wire              init_status_in,
	output reg               init_status_out,
	output reg               init_status_oe,
	output reg               user_mode,
	output reg               dual_pins_user
);

	localparam ST_CLEAR   = 2'd0;
	localparam ST_LOAD    = 2'd1;
	localparam ST_RELEASE = 2'd2;
	localparam ST_USER    = 2'd3;
	localparam [31:0] CLEAR_FULL  = `CLEAR_CYCLES;
	localparam [15:0] CLEAR_COUNT = CLEAR_FULL[15:0];
	localparam [31:0] DIV_FULL    = CLOCK_DIV / 2;
	localparam [7:0]  DIV_HALF    = DIV_FULL[7:0];

	// Data lines zero to three hold the high nibble, so the byte is nibble-swapped.
	function [7:0] nibble_swap;
		input [7:0] value;
		begin
			nibble_swap = {value[3:0], value[7:4]};
		end
	endfunction

	function is_parallel;
		input [2:0] mode;
		begin
			is_parallel = (mode == `MODE_MASTER_PAR) || (mode == `MODE_SLAVE_PAR);
		end
	endfunction

	function is_master;
		input [2:0] mode;
		begin
			is_master = (mode == `MODE_MASTER_PAR) || (mode == `MODE_MASTER_SERIAL);
		end
	endfunction

	reg  [15:0] control;
	reg         prog_sync1;
	reg         prog_sync2;
	reg  [2:0]  clk_sync;
	reg         sel_s1;
	reg         sel_s2;
	reg         rw_s1;
	reg         rw_s2;
	reg  [7:0]  bus_s1;
	reg  [7:0]  bus_s2;
	reg  [2:0]  mode_s1;
	reg  [2:0]  mode_s2;
	reg         pud_s1;
	reg         pud_s2;
	reg         fin_s1;
	reg         fin_s2;
	reg         init_s1;
	reg         init_s2;
	reg         init_s3;
	reg  [1:0]  state;
	reg  [15:0] clear_cnt;
	reg  [2:0]  mode;
	reg  [7:0]  byte_count;
	reg  [7:0]  read_ptr;
	reg  [7:0]  div_cnt;
	reg         div_rise;
	reg  [7:0]  config_mem [0:(1<<DEPTH_W)-1];
	reg         aw_got;
	reg         w_got;
	reg  [ADDR_W-1:0] aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;

	wire        totem     = control[`CTRL_TOTEM_BIT];
	wire        persist   = control[`CTRL_PERSIST_BIT];
	wire        throttle  = control[`CTRL_THROTTLE_BIT];
	wire [7:0]  length    = control[`CTRL_LEN_MSB:`CTRL_LEN_LSB];
	wire        port_live = is_parallel(mode) &&
		(state == ST_LOAD || (state == ST_USER && persist));
	wire        link_rise = is_master(mode) ? div_rise : (clk_sync[1] & ~clk_sync[2]);
	wire        take_byte = link_rise && port_live && state == ST_LOAD &&
		!sel_s2 && !rw_s2 && !busy_out;
	wire        give_byte = link_rise && port_live && persist &&
		!sel_s2 && rw_s2;
	wire [31:0] status_word = {16'h0000, byte_count, config_byte_bus_oe, busy_out,
		fin_s2, mode, state};

	// Release of the program input is synchronised; assertion acts at once.
	always @(posedge aclk or negedge program_reset_n) begin
		if (!program_reset_n) begin
			prog_sync1 <= 1'b0;
			prog_sync2 <= 1'b0;
		end else begin
			prog_sync1 <= 1'b1;
			prog_sync2 <= prog_sync1;
		end
	end

	// Pin synchronisers: the first stage feeds only the second.
	always @(posedge aclk) begin
		if (!aresetn) begin
			clk_sync <= 3'h0;
			sel_s1   <= 1'b1;
			sel_s2   <= 1'b1;
			rw_s1    <= 1'b1;
			rw_s2    <= 1'b1;
			bus_s1   <= 8'h00;
			bus_s2   <= 8'h00;
			mode_s1  <= `MODE_SLAVE_SERIAL;
			mode_s2  <= `MODE_SLAVE_SERIAL;
			pud_s1   <= 1'b0;
			pud_s2   <= 1'b0;
			fin_s1   <= 1'b0;
			fin_s2   <= 1'b0;
			init_s1  <= 1'b0;
			init_s2  <= 1'b0;
			init_s3  <= 1'b0;
		end else begin
			clk_sync <= {clk_sync[1:0], config_clock_in};
			sel_s1   <= select_n;
			sel_s2   <= sel_s1;
			rw_s1    <= read_write_n;
			rw_s2    <= rw_s1;
			bus_s1   <= config_byte_bus_in;
			bus_s2   <= bus_s1;
			mode_s1  <= mode_select_pins;
			mode_s2  <= mode_s1;
			pud_s1   <= pullup_disable;
			pud_s2   <= pud_s1;
			fin_s1   <= finish_in;
			fin_s2   <= fin_s1;
			init_s1  <= init_status_in;
			init_s2  <= init_s1;
			init_s3  <= init_s2;
		end
	end

	// Configuration sequence; a low program input clears it and the byte count, but config_mem keeps the loaded bytes.
	always @(posedge aclk or negedge program_reset_n) begin
		if (!program_reset_n) begin
			state      <= ST_CLEAR;
			clear_cnt  <= 16'h0000;
			mode       <= `MODE_SLAVE_SERIAL;
			byte_count <= 8'h00;
			read_ptr   <= 8'h00;
			busy_out   <= 1'b0;
			config_byte_bus_out <= 8'h00;
			config_byte_bus_oe  <= 1'b0;
		end else if (!aresetn || !prog_sync2) begin
			state      <= ST_CLEAR;
			clear_cnt  <= 16'h0000;
			mode       <= `MODE_SLAVE_SERIAL;
			byte_count <= 8'h00;
			read_ptr   <= 8'h00;
			busy_out   <= 1'b0;
			config_byte_bus_out <= 8'h00;
			config_byte_bus_oe  <= 1'b0;
		end else begin
			case (state)
				ST_CLEAR: begin
					if (clear_cnt < CLEAR_COUNT) begin
						clear_cnt <= clear_cnt + 16'h0001;
					end else if (init_s2 && !init_s3) begin
						mode  <= mode_s2;
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (byte_count >= length) begin
						state <= ST_RELEASE;
					end
				end
				ST_RELEASE: begin
					if (fin_s2) begin
						state <= ST_USER;
					end
				end
				ST_USER: begin
					state <= ST_USER;
				end
				default: begin
					state <= ST_CLEAR;
				end
			endcase
			if (take_byte) begin
				byte_count <= byte_count + 8'h01;
			end
			if (link_rise) begin
				busy_out <= take_byte && throttle;
			end
			if (give_byte) begin
				config_byte_bus_out <= nibble_swap(config_mem[read_ptr[DEPTH_W-1:0]]);
				config_byte_bus_oe  <= 1'b1;
				read_ptr <= (read_ptr + 8'h01 >= byte_count) ? 8'h00 : read_ptr + 8'h01;
			end else if (sel_s2 || !rw_s2 || !port_live || !persist) begin
				config_byte_bus_oe <= 1'b0;
			end
		end
	end

	always @(posedge aclk) begin
		if (take_byte) begin
			config_mem[byte_count[DEPTH_W-1:0]] <= nibble_swap(bus_s2);
		end
	end

	// Master modes make the link clock by dividing the block clock.
	always @(posedge aclk) begin
		if (!aresetn || !prog_sync2) begin
			div_cnt          <= 8'h00;
			div_rise         <= 1'b0;
			config_clock_out <= 1'b0;
		end else if (div_cnt + 8'h01 >= DIV_HALF) begin
			div_cnt          <= 8'h00;
			config_clock_out <= ~config_clock_out;
			div_rise         <= ~config_clock_out;
		end else begin
			div_cnt  <= div_cnt + 8'h01;
			div_rise <= 1'b0;
		end
	end

	// Pin drivers, all registered.
	always @(posedge aclk or negedge program_reset_n) begin
		if (!program_reset_n) begin
			finish_out      <= 1'b0;
			finish_oe       <= 1'b1;
			init_status_out <= 1'b0;
			init_status_oe  <= 1'b1;
			config_clock_oe <= 1'b0;
			busy_oe         <= 1'b0;
			pullup_enable   <= 1'b1;
			user_mode       <= 1'b0;
			dual_pins_user  <= 1'b0;
		end else begin
			init_status_out <= 1'b0;
			init_status_oe  <= (state == ST_CLEAR) && (clear_cnt < CLEAR_COUNT);
			if (state == ST_RELEASE || state == ST_USER) begin
				finish_out <= totem;
				finish_oe  <= totem;
			end else begin
				finish_out <= 1'b0;
				finish_oe  <= 1'b1;
			end
			config_clock_oe <= is_master(mode) && state != ST_CLEAR &&
				(state != ST_USER || persist);
			busy_oe         <= port_live && !sel_s2;
			pullup_enable   <= (state != ST_USER) && !pud_s2;
			user_mode       <= (state == ST_USER);
			dual_pins_user  <= (mode == `MODE_BOUNDARY_SCAN) ||
				(state != ST_CLEAR && !port_live);
		end
	end

	// Register slave: one write and one read under way at a time.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
			aw_got        <= 1'b0;
			w_got         <= 1'b0;
			aw_addr       <= {ADDR_W{1'b0}};
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			control       <= `CTRL_RESET;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr       <= s_axi_awaddr;
				aw_got        <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				w_got        <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid) begin
				aw_got       <= 1'b0;
				w_got        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr[3:0] == `OFFS_CONTROL) begin
					s_axi_bresp <= `RESP_OKAY;
					if (w_strb[0]) begin
						control[7:0] <= w_data[7:0];
					end
					if (w_strb[1]) begin
						control[15:8] <= w_data[15:8];
					end
				end else if (aw_addr[3:0] == `OFFS_STATUS) begin
					s_axi_bresp <= `RESP_OKAY;
				end else begin
					s_axi_bresp <= `RESP_DECERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			if (s_axi_araddr[3:0] == `OFFS_CONTROL) begin
				s_axi_rdata <= {16'h0000, control};
				s_axi_rresp <= `RESP_OKAY;
			end else if (s_axi_araddr[3:0] == `OFFS_STATUS) begin
				s_axi_rdata <= status_word;
				s_axi_rresp <= `RESP_OKAY;
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `RESP_DECERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // parallel_config_port
`default_nettype wire

// >>> tb/parallel_config_port_assertions.sv
// Concurrent checks on the parallel configuration port pins.
`timescale 1ns/1ps
`default_nettype none
module parallel_config_port_assertions (
	input wire aclk,
	input wire aresetn,
	input wire program_reset_n,
	input wire select_n,
	input wire read_write_n,
	input wire busy_oe,
	input wire config_byte_bus_oe,
	input wire finish_in,
	input wire finish_out,
	input wire finish_oe,
	input wire init_status_out,
	input wire init_status_oe,
	input wire user_mode,
	input wire dual_pins_user,
	input wire pullup_disable,
	input wire pullup_enable
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_prog_finish; !program_reset_n |-> finish_oe && !finish_out; endproperty
	a_prog_finish: assert property (p_prog_finish) else $error("finish not held low");
	property p_prog_init; !program_reset_n |-> init_status_oe && !init_status_out; endproperty
	a_prog_init: assert property (p_prog_init) else $error("init not held low");
	property p_prog_user; !program_reset_n |-> !user_mode && !dual_pins_user; endproperty
	a_prog_user: assert property (p_prog_user) else $error("user state during program");
	property p_busy_hiz; select_n [*5] |-> !busy_oe; endproperty
	a_busy_hiz: assert property (p_busy_hiz) else $error("flow control driven");
	property p_rb_sel; select_n [*5] |-> !config_byte_bus_oe; endproperty
	a_rb_sel: assert property (p_rb_sel) else $error("bus driven unselected");
	property p_rb_write; !read_write_n [*5] |-> !config_byte_bus_oe; endproperty
	a_rb_write: assert property (p_rb_write) else $error("bus driven in load");
	property p_user_finish; $rose(user_mode) |-> finish_in; endproperty
	a_user_finish: assert property (p_user_finish) else $error("user mode with finish low");
	property p_pullup; !pullup_disable [*5] ##0 !user_mode |-> pullup_enable; endproperty
	a_pullup: assert property (p_pullup) else $error("pull-ups off");
endmodule // parallel_config_port_assertions
`default_nettype wire

// >>> tb/cfg_ctrl.sv
// Behavioural model of the external configuration controller.
`timescale 1ns/1ps
`default_nettype none
module cfg_ctrl (
	output logic       config_clock_in,
	output logic       select_n,
	output logic       read_write_n,
	output logic [7:0] pdata,
	input  wire        busy_out,
	input  wire        busy_oe
);
	integer retries = 0;
	logic   skip;
	initial begin
		config_clock_in = 1'h0;
		select_n = 1'h1;
		read_write_n = 1'h1;
		pdata = 8'h5a;
	end
	// One link period; the link clock pulses whether or not select is low, and every pin
	// change falls between two block clock edges.
	task automatic cyc(input logic s, input logic rw, input logic [7:0] b);
		#13;
		skip = busy_oe && busy_out;
		select_n = s;
		read_write_n = rw;
		pdata = b;
		#140 config_clock_in = 1'h1;
		#160 config_clock_in = 1'h0;
		#7;
	endtask
	// Offers a byte again for as long as flow control held it off.
	task automatic put(input logic [7:0] b);
		do begin
			cyc(1'h0, 1'h0, b);
			retries += skip;
		end while (skip);
	endtask
	task automatic idle;
		#13;
		select_n = 1'h1;
		pdata = ~pdata;
	endtask
endmodule // cfg_ctrl
`default_nettype wire

// >>> tb/parallel_config_port_test.sv
// Self-checking bench for the parallel configuration port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, a) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("mismatch t=%0t exp=%h got=%h", $time, e, a); end end
module parallel_config_port_test;
	logic        aclk = 1'h0, aresetn = 1'h0, program_reset_n = 1'h0, pullup_disable = 1'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [2:0]  mode_select_pins = 3'h6;
	wire  [31:0] s_axi_rdata;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         config_clock_in, config_clock_out, config_clock_oe, pullup_enable;
	wire         select_n, read_write_n, busy_out, busy_oe, finish_out, finish_oe;
	wire         init_status_out, init_status_oe, user_mode, dual_pins_user;
	wire         config_byte_bus_oe;
	wire  [7:0]  config_byte_bus_out, pdata;
	wire  [7:0]  config_byte_bus_in = config_byte_bus_oe ? config_byte_bus_out : pdata;
	logic        finish_low = 1'h0;
	wire         finish_in = finish_oe ? finish_out : !finish_low;
	wire         init_status_in = init_status_oe ? init_status_out : 1'h1;
	integer      failures = 0, checks = 0, seed = 32'h9e39;
	logic [33:0] q[$];
	logic [33:0] me, ma;
	logic [7:0]  b0, b1;

	parallel_config_port i_dut (.*);
	cfg_ctrl cfg (.*);

	always #20 aclk = ~aclk;

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		q.push_back(34'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		q.push_back(e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
	endtask

	// Pulses the program input and waits until the mode pins have been latched.
	task automatic boot(input logic [2:0] m);
		program_reset_n <= 1'h0;
		mode_select_pins <= m;
		repeat (2) @(posedge aclk);
		program_reset_n <= 1'h1;
		while (init_status_oe) @(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask

	// Takes the oldest expected response whenever the slave answers.
	always @(posedge aclk) begin
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
			me = q.pop_front();
			ma = s_axi_bvalid ? {s_axi_bresp, 32'h0} :
				{s_axi_rresp, me[33:32] == 2'h3 ? 32'h0 : s_axi_rdata};
			`CHK(me, ma)
		end
	end

	task close_out;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#400000;
		failures++;
		close_out;
	end

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		rd(4'h0, {2'h0, 32'h100});
		rd(4'h8, {2'h3, 32'h0});
		wr(4'h0, 32'h0207);
		rd(4'h0, {2'h0, 32'h0207});
		@(posedge aclk);
		program_reset_n <= 1'h1;
		while (init_status_oe) @(posedge aclk);
		pullup_disable <= 1'h1;
		repeat (4) @(posedge aclk);
		`CHK(1'h0, pullup_enable)
		pullup_disable <= 1'h0;
		b0 = $random(seed);
		b1 = $random(seed);
		cfg.cyc(1'h1, 1'h0, ~b0);
		cfg.put(b0);
		cfg.put(b1);
		cfg.cyc(1'h0, 1'h0, ~b1);
		cfg.idle;
		`CHK(1, cfg.retries)
		while (!user_mode) @(posedge aclk);
		`CHK(1'h1, finish_out)
		`CHK(3'h0, {config_clock_oe, dual_pins_user, pullup_enable})
		rd(4'h4, {2'h0, 32'h023b});
		cfg.cyc(1'h0, 1'h1, ~b1);
		repeat (2) @(posedge aclk);
		`CHK({1'h1, b0}, {config_byte_bus_oe, config_byte_bus_out})
		program_reset_n <= 1'h0;
		cfg.idle;
		repeat (2) @(posedge aclk);
		`CHK(2'h0, {user_mode, finish_out})
		rd(4'h4, {2'h0, 32'h001c});
		boot(3'h5);
		`CHK(2'h2, {dual_pins_user, config_clock_oe})
		boot(3'h3);
		`CHK(2'h1, {dual_pins_user, config_clock_oe})
		wr(4'h0, 32'h0);
		finish_low <= 1'h1;
		boot(3'h6);
		repeat (8) @(posedge aclk);
		`CHK(3'h0, {user_mode, finish_oe, finish_in})
		finish_low <= 1'h0;
		repeat (6) @(posedge aclk);
		`CHK(2'h3, {user_mode, dual_pins_user})
		close_out;
	end
endmodule // parallel_config_port_test

bind parallel_config_port parallel_config_port_assertions i_chk (.*);
`default_nettype wire
